// ---- citeu_top.sv ----
/*
  Top of the exception unit: status word, recognition, acknowledge and vector fetch.
  Assumes one event strobe per cycle from the core and a bus unit for the cycles.
*/
`timescale 1ns/1ps
module citeu_top
  import citeu_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [2:0] interrupt_level_inputs,
  input wire citeu_pkg::citeu_evt_t evt,
  input wire logic sr_wr,
  input wire logic [15:0] sr_wdata,
  input wire logic transfer_ack_input,
  input wire logic bus_fault_input,
  input wire logic autovector_input,
  input wire logic [7:0] iack_data_in,
  input wire logic fetch_done,
  input wire logic [31:0] fetch_data,
  output logic [15:0] status_word_ff,
  output logic busy_ff,
  output logic iack_ff,
  output logic [2:0] iack_lvl_ff,
  output logic vfetch_req_ff,
  output logic [31:0] vfetch_addr_ff,
  output citeu_pkg::citeu_exc_t exc_ff
);
  import citeu_pkg::*;

  citeu_state_t state_ff;
  citeu_state_t nxt_state;
  citeu_cls_t cls;
  logic [2:0] pend_lvl;
  logic nmi_edge;
  logic [2:0] mask;
  logic user_mode;
  logic take_int;
  logic int_go;
  logic [2:0] take_lvl;
  logic dec_exc;
  logic [7:0] dec_vec;
  logic exe_exc;
  logic [7:0] exe_vec;
  logic recog;
  logic [7:0] vec_ff;
  logic [7:0] nxt_vec;
  logic short_ff;
  logic [15:0] sr_copy_ff;
  logic [31:0] pc_ff;
  logic iack_end;

  // ==========================================================
  // Submodules
  citeu_decode u_dec (
    .opword(evt.opword),
    .insn_legal(evt.insn_legal),
    .cls(cls)
  );

  citeu_irq_pend u_pend (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .level_in(interrupt_level_inputs),
    .take_nmi(int_go && nmi_edge),
    .pend_lvl_ff(pend_lvl),
    .nmi_edge_ff(nmi_edge)
  );

  // ==========================================================
  // Recognition
  assign mask = status_word_ff[SR_MASK_MSB:SR_MASK_LSB];
  assign user_mode = !status_word_ff[SR_S_BIT];
  // Zero never exceeds a mask, so no request is no interrupt
  assign take_int = state_ff == ST_IDLE && evt.boundary
                    && (nmi_edge || pend_lvl > mask);
  assign take_lvl = nmi_edge ? LVL_NMI : pend_lvl;
  // Edge latch only clears when the interrupt really wins over a trap
  assign int_go = take_int && !(evt.decode_valid && dec_exc) && !(evt.exec_done && exe_exc);

  always_comb
  begin
    dec_exc = 1'b1;
    dec_vec = VEC_ILLEGAL;
    if (cls.line_a)
      dec_vec = VEC_LINE_A;
    else if (cls.line_f)
      dec_vec = VEC_LINE_F;
    else if (cls.illegal)
      dec_vec = VEC_ILLEGAL;
    else if (cls.priv && user_mode)
      dec_vec = VEC_PRIV;
    else
      dec_exc = 1'b0;
  end

  always_comb
  begin
    exe_exc = 1'b1;
    exe_vec = VEC_TRAP_BASE + {4'h0, evt.opword[3:0]};
    if (cls.syscall)
      exe_vec = VEC_TRAP_BASE + {4'h0, evt.opword[3:0]};
    else if (cls.ovf && evt.ovf_cond)
      exe_vec = VEC_OVF;
    else if (cls.chk && evt.bounds_cond)
      exe_vec = VEC_BOUNDS;
    else if (cls.div && evt.divisor_zero)
      exe_vec = VEC_ZERO_DIV;
    else
      exe_exc = 1'b0;
  end

  assign recog = state_ff == ST_IDLE
                 && ((evt.decode_valid && dec_exc) || (evt.exec_done && exe_exc) || take_int);
  assign iack_end = state_ff == ST_IACK
                    && (bus_fault_input || autovector_input || transfer_ack_input);

  // ==========================================================
  // Sequencer
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (evt.decode_valid && dec_exc)
          nxt_state = ST_VFETCH;
        else if (evt.exec_done && exe_exc)
          nxt_state = ST_VFETCH;
        else if (take_int)
          nxt_state = ST_IACK;
      end
      ST_IACK:
      begin
        if (iack_end)
          nxt_state = ST_VFETCH;
      end
      ST_VFETCH:
      begin
        if (fetch_done)
          nxt_state = ST_IDLE;
      end
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      busy_ff <= 1'b0;
    else
      busy_ff <= nxt_state != ST_IDLE;
  end

  // ==========================================================
  // Status word
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      status_word_ff <= SR_RESET;
    else if (recog)
    begin
      status_word_ff[SR_S_BIT] <= 1'b1;
      status_word_ff[SR_T_BIT] <= 1'b0;
      if (!(evt.decode_valid && dec_exc) && !(evt.exec_done && exe_exc))
        status_word_ff[SR_MASK_MSB:SR_MASK_LSB] <= take_lvl;
    end
    else if (sr_wr)
      status_word_ff <= sr_wdata;
  end

  // Copy captured from the unmodified word
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      sr_copy_ff <= '0;
    else if (recog)
      sr_copy_ff <= status_word_ff;
  end

  // ==========================================================
  // Stacked program counter
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      pc_ff <= '0;
    else if (recog && evt.decode_valid && dec_exc)
      pc_ff <= evt.insn_pc;
    else if (recog)
      pc_ff <= evt.next_pc;
  end

  // ==========================================================
  // Vector selection
  always_comb
  begin
    nxt_vec = vec_ff;
    if (state_ff == ST_IDLE && evt.decode_valid && dec_exc)
      nxt_vec = dec_vec;
    else if (state_ff == ST_IDLE && evt.exec_done && exe_exc)
      nxt_vec = exe_vec;
    else if (state_ff == ST_IACK && bus_fault_input)
      nxt_vec = VEC_SPURIOUS;
    else if (state_ff == ST_IACK && autovector_input)
      nxt_vec = VEC_AUTO_BASE + {5'h00, iack_lvl_ff};
    else if (state_ff == ST_IACK && transfer_ack_input)
      nxt_vec = iack_data_in;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      vec_ff <= '0;
    else
      vec_ff <= nxt_vec;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      short_ff <= 1'b0;
    else if (recog)
      short_ff <= 1'b0;
    else if (state_ff == ST_IACK && bus_fault_input)
      short_ff <= 1'b1;
  end

  // ==========================================================
  // Acknowledge cycle
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      iack_ff <= 1'b0;
      iack_lvl_ff <= LVL_NONE;
    end
    else if (take_int && !(evt.decode_valid && dec_exc) && !(evt.exec_done && exe_exc))
    begin
      iack_ff <= 1'b1;
      iack_lvl_ff <= take_lvl;
    end
    else if (iack_end)
      iack_ff <= 1'b0;
  end

  // ==========================================================
  // Vector fetch
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      vfetch_req_ff <= 1'b0;
      vfetch_addr_ff <= '0;
    end
    else if (nxt_state == ST_VFETCH && !(state_ff == ST_VFETCH && fetch_done))
    begin
      vfetch_req_ff <= 1'b1;
      vfetch_addr_ff <= {22'h0, nxt_vec, 2'b00};
    end
    else
      vfetch_req_ff <= 1'b0;
  end

  // ==========================================================
  // Dispatch record
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      exc_ff <= '0;
    else if (state_ff == ST_VFETCH && fetch_done)
    begin
      exc_ff.valid <= 1'b1;
      exc_ff.vector <= vec_ff;
      exc_ff.short_frame <= short_ff;
      exc_ff.sr_copy <= sr_copy_ff;
      exc_ff.stacked_pc <= pc_ff;
      exc_ff.new_pc <= fetch_data;
    end
    else
      exc_ff.valid <= 1'b0;
  end

  // ==========================================================
  // Checks
  mask_gate_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state_ff == ST_IDLE && evt.boundary && !evt.decode_valid && !evt.exec_done
     && !nmi_edge && pend_lvl <= mask) |=> !iack_ff)
    else $error("masked request acknowledged");

  nmi_take_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state_ff == ST_IDLE && evt.boundary && nmi_edge && !evt.decode_valid && !evt.exec_done)
    |=> iack_ff && iack_lvl_ff == LVL_NMI)
    else $error("level seven edge not taken");

  iack_mask_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(iack_ff) |-> status_word_ff[SR_MASK_MSB:SR_MASK_LSB] == iack_lvl_ff
      && status_word_ff[SR_S_BIT] && !status_word_ff[SR_T_BIT])
    else $error("mask or mode not set on acknowledge");

  sr_copy_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    recog |=> sr_copy_ff == $past(status_word_ff))
    else $error("status copy not pre-exception");

  spurious_vec_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state_ff == ST_IACK && bus_fault_input) |=> vec_ff == VEC_SPURIOUS && short_ff
      && vfetch_req_ff)
    else $error("bus fault not spurious");

  autovec_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state_ff == ST_IACK && !bus_fault_input && autovector_input)
    |=> vec_ff == VEC_AUTO_BASE + {5'h00, $past(iack_lvl_ff)})
    else $error("autovector wrong");

  vec_addr_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    vfetch_req_ff |-> vfetch_addr_ff == {22'h0, vec_ff, 2'b00})
    else $error("vector address not four times number");

  syscall_vec_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state_ff == ST_IDLE && !evt.decode_valid && evt.exec_done && cls.syscall)
    |=> vec_ff == VEC_TRAP_BASE + {4'h0, $past(evt.opword[3:0])} && pc_ff == $past(evt.next_pc))
    else $error("syscall vector wrong");

  priv_vec_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state_ff == ST_IDLE && evt.decode_valid && !cls.illegal && !cls.line_a && !cls.line_f
     && cls.priv && user_mode)
    |=> vec_ff == VEC_PRIV && pc_ff == $past(evt.insn_pc))
    else $error("privilege violation not raised");

  dispatch_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state_ff == ST_VFETCH && fetch_done) |=> exc_ff.valid && exc_ff.new_pc == $past(fetch_data)
      ##1 !exc_ff.valid)
    else $error("dispatch record wrong");
endmodule // citeu_top

// ---- citeu_pkg.sv ----
/*
  Constants, field layouts and carrier types of the exception unit.
  Assumes a core that strobes decode, execute and instruction boundary events.
*/
// Summary of operation
// - Interrupt levels one to seven, seven highest
// - Three-bit mask inhibits levels at or below it
// - Rising to level seven always interrupts
// - Held seven taken when mask drops below
// - Encoded level input, zero means no request
// - Requests pending, checked only between instructions
// - Copy status, supervisor, no trace, set mask
// - Acknowledge cycle shows level on address
// - Autovector request yields level-derived vector
// - Spurious vector 24, autovectors 25 to 31
// - Bus fault in acknowledge means spurious
// - Spurious uses short frame, spurious vector
// - Interrupt saves next pc, loads fetched vector
// - Traps copy status, supervisor, internal vector
// - Syscall operand n selects vector 32+n
// - Traps stack pc of following instruction
// - Syscall always; checks conditional; zero divide
// - Fixed vectors for illegal through line-f
// - Unknown words and three patterns are illegal
// - Line-a and line-f words have own vectors
// - Illegal word stacks frame, fetches illegal vector
// - Privileged instructions trap in user mode
// - Privilege violation stacks faulting instruction address
package citeu_pkg;
  // ==========================================================
  // Levels and status word layout
  localparam logic [2:0] LVL_NONE = 3'h0;
  localparam logic [2:0] LVL_NMI = 3'h7;
  localparam int SR_T_BIT = 15;
  localparam int SR_S_BIT = 13;
  localparam int SR_MASK_LSB = 8;
  localparam int SR_MASK_MSB = 10;
  localparam logic [15:0] SR_RESET = 16'h2700;
  // ==========================================================
  // Vector numbers
  localparam logic [7:0] VEC_ILLEGAL = 8'h04;
  localparam logic [7:0] VEC_ZERO_DIV = 8'h05;
  localparam logic [7:0] VEC_BOUNDS = 8'h06;
  localparam logic [7:0] VEC_OVF = 8'h07;
  localparam logic [7:0] VEC_PRIV = 8'h08;
  localparam logic [7:0] VEC_LINE_A = 8'h0a;
  localparam logic [7:0] VEC_LINE_F = 8'h0b;
  localparam logic [7:0] VEC_SPURIOUS = 8'h18;
  localparam logic [7:0] VEC_AUTO_BASE = 8'h18;
  localparam logic [7:0] VEC_TRAP_BASE = 8'h20;
  // ==========================================================
  // Opcode patterns, value and compare mask
  localparam logic [15:0] OP_BAD_A = 16'h4afa;
  localparam logic [15:0] OP_BAD_B = 16'h4afb;
  localparam logic [15:0] OP_BAD_C = 16'h4afc;
  localparam logic [3:0] OP_LINE_A = 4'ha;
  localparam logic [3:0] OP_LINE_F = 4'hf;
  localparam logic [15:0] OP_ANDI_SR = 16'h027c;
  localparam logic [15:0] OP_EORI_SR = 16'h0a7c;
  localparam logic [15:0] OP_ORI_SR = 16'h007c;
  localparam logic [15:0] OP_TO_SR = 16'h46c0;
  localparam logic [15:0] OP_FROM_SR = 16'h40c0;
  localparam logic [15:0] M_EA = 16'hffc0;
  localparam logic [15:0] OP_USP = 16'h4e60;
  localparam logic [15:0] OP_SYSCALL = 16'h4e40;
  localparam logic [15:0] M_LOW4 = 16'hfff0;
  localparam logic [15:0] OP_RESET = 16'h4e70;
  localparam logic [15:0] OP_HALT = 16'h4e72;
  localparam logic [15:0] OP_RET = 16'h4e73;
  localparam logic [15:0] OP_OVF = 16'h4e76;
  localparam logic [15:0] OP_ALT = 16'h0e00;
  localparam logic [15:0] M_ALT = 16'hff00;
  localparam logic [15:0] OP_CHK = 16'h4180;
  localparam logic [15:0] M_CHK = 16'hf1c0;
  localparam logic [15:0] OP_SIGNED_QUOTIENT_OP = 16'h81c0;
  localparam logic [15:0] OP_UNSIGNED_QUOTIENT_OP = 16'h80c0;
  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic boundary;
    logic decode_valid;
    logic [15:0] opword;
    logic insn_legal;
    logic exec_done;
    logic ovf_cond;
    logic bounds_cond;
    logic divisor_zero;
    logic [31:0] insn_pc;
    logic [31:0] next_pc;
  } citeu_evt_t;
  typedef struct packed {
    logic illegal;
    logic line_a;
    logic line_f;
    logic priv;
    logic syscall;
    logic ovf;
    logic chk;
    logic div;
  } citeu_cls_t;
  typedef struct packed {
    logic valid;
    logic [7:0] vector;
    logic short_frame;
    logic [15:0] sr_copy;
    logic [31:0] stacked_pc;
    logic [31:0] new_pc;
  } citeu_exc_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_IACK = 3'b010,
    ST_VFETCH = 3'b100
  } citeu_state_t;
endpackage

// ---- citeu_decode.sv ----
/*
  Opcode classifier for the exception unit.
  Assumes the core supplies the first word and its own legality verdict.
*/
`timescale 1ns/1ps
module citeu_decode
  import citeu_pkg::*;
(
  input wire logic [15:0] opword,
  input wire logic insn_legal,
  output citeu_pkg::citeu_cls_t cls
);
  import citeu_pkg::*;

  logic la;
  logic lf;
  // ==========================================================
  // Classification
  assign la = opword[15:12] == OP_LINE_A;
  assign lf = opword[15:12] == OP_LINE_F;
  always_comb
  begin
    cls = '0;
    cls.line_a = la;
    cls.line_f = lf;
    cls.illegal = opword == OP_BAD_A || opword == OP_BAD_B || opword == OP_BAD_C
                  || (!insn_legal && !la && !lf);
    cls.priv = opword == OP_ANDI_SR || opword == OP_EORI_SR || opword == OP_ORI_SR
               || (opword & M_EA) == OP_TO_SR || (opword & M_EA) == OP_FROM_SR
               || (opword & M_LOW4) == OP_USP || opword == OP_RESET
               || opword == OP_RET || opword == OP_HALT
               || ((opword & M_ALT) == OP_ALT && opword[7:6] != 2'b11);
    cls.syscall = (opword & M_LOW4) == OP_SYSCALL;
    cls.ovf = opword == OP_OVF;
    cls.chk = (opword & M_CHK) == OP_CHK;
    cls.div = (opword & M_CHK) == OP_SIGNED_QUOTIENT_OP || (opword & M_CHK) == OP_UNSIGNED_QUOTIENT_OP;
  end
endmodule // citeu_decode

// ---- citeu_exc.sv ----
/*
  Interrupt request pending: registered request level and level seven edge latch.
  Assumes the core strobes events, stacks the frame and then loads new_pc.
*/
`timescale 1ns/1ps
module citeu_irq_pend
  import citeu_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [2:0] level_in,
  input wire logic take_nmi,
  output logic [2:0] pend_lvl_ff,
  output logic nmi_edge_ff
);
  import citeu_pkg::*;

  logic [2:0] prev_ff;
  // ==========================================================
  // Pending level latch
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prev_ff <= LVL_NONE;
      pend_lvl_ff <= LVL_NONE;
    end
    else
    begin
      prev_ff <= level_in;
      pend_lvl_ff <= level_in;
    end
  end
  // ==========================================================
  // Level seven edge, set wins over clear
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      nmi_edge_ff <= 1'b0;
    else if (level_in == LVL_NMI && prev_ff != LVL_NMI)
      nmi_edge_ff <= 1'b1;
    else if (take_nmi)
      nmi_edge_ff <= 1'b0;
  end
  nmi_edge_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (level_in == LVL_NMI && prev_ff != LVL_NMI) |=> nmi_edge_ff)
    else $error("level seven edge not latched");
endmodule // citeu_irq_pend

// ---- citeu_periph_model.sv ----
/*
  Partner model: interrupting peripherals, acknowledge logic and vector memory.
  Assumes the bench sets request level, response mode and answer delay.
*/
`timescale 1ns/1ps
module citeu_periph_model
  import citeu_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [2:0] lvl_req,
  input wire logic [1:0] mode,
  input wire logic [3:0] dly,
  input wire logic [7:0] vec_in,
  input wire logic iack_ff,
  input wire logic vfetch_req_ff,
  input wire logic [31:0] vfetch_addr_ff,
  output logic [2:0] interrupt_level_inputs,
  output logic transfer_ack_input,
  output logic bus_fault_input,
  output logic autovector_input,
  output logic [7:0] iack_data_in,
  output logic fetch_done,
  output logic [31:0] fetch_data
);
  logic [3:0] acnt_ff;
  logic [3:0] fcnt_ff;
  logic fbusy_ff;
  logic [31:0] faddr_ff;
  // ==========================================================
  // Request level
  always_ff @(negedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      interrupt_level_inputs <= 3'h0;
    else
      interrupt_level_inputs <= lvl_req;
  end
  // ==========================================================
  // Acknowledge responder, released data lines toggle
  always_ff @(negedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      acnt_ff <= 4'h0;
      transfer_ack_input <= 1'b0;
      bus_fault_input <= 1'b0;
      autovector_input <= 1'b0;
      iack_data_in <= 8'h00;
    end
    else if (!iack_ff)
    begin
      acnt_ff <= 4'h0;
      transfer_ack_input <= 1'b0;
      bus_fault_input <= 1'b0;
      autovector_input <= 1'b0;
      iack_data_in <= ~iack_data_in;
    end
    else if (acnt_ff < dly)
      acnt_ff <= acnt_ff + 4'h1;
    else
    begin
      transfer_ack_input <= (mode == 2'h0) || (mode == 2'h3);
      autovector_input <= (mode == 2'h1);
      bus_fault_input <= (mode == 2'h2);
      iack_data_in <= (mode == 2'h3) ? 8'h0f : vec_in;
    end
  end
  // ==========================================================
  // Vector memory
  always_ff @(negedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fbusy_ff <= 1'b0;
      fcnt_ff <= 4'h0;
      faddr_ff <= 32'h0;
      fetch_done <= 1'b0;
      fetch_data <= 32'h0;
    end
    else if (vfetch_req_ff && !fbusy_ff)
    begin
      fbusy_ff <= 1'b1;
      fcnt_ff <= 4'h0;
      faddr_ff <= vfetch_addr_ff;
      fetch_done <= 1'b0;
    end
    else if (fbusy_ff && fcnt_ff < dly)
      fcnt_ff <= fcnt_ff + 4'h1;
    else if (fbusy_ff)
    begin
      fbusy_ff <= 1'b0;
      fetch_done <= 1'b1;
      fetch_data <= faddr_ff ^ 32'h00c0_0000;
    end
    else
    begin
      fetch_done <= 1'b0;
      fetch_data <= ~fetch_data;
    end
  end
endmodule // citeu_periph_model

// ---- citeu_top_tb.sv ----
/*
  Self-checking bench of the exception unit with its partner model.
  Assumes the event contract of the unit and a 250 MHz core clock.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module citeu_top_tb;
  import citeu_pkg::*;
  logic core_clk, arst_n, sr_wr, iack_ff, busy_ff, vfetch_req_ff, tack, bfault, avec, fdone;
  logic [2:0] lvl_req, ilvl, iack_lvl_ff;
  logic [1:0] mode;
  logic [3:0] dly;
  logic [7:0] vec_in, idata;
  logic [15:0] sr_wdata, status_word_ff, sr_m, op;
  logic [31:0] vfetch_addr_ff, fdata, seed;
  citeu_evt_t evt;
  citeu_exc_t exc_ff;
  int err_count, checks;
  logic [15:0] priv_ops [10] = '{16'h027c, 16'h0a7c, 16'h007c, 16'h46c0, 16'h40c0,
                                 16'h4e60, 16'h4e70, 16'h4e72, 16'h4e73, 16'h0e00};
  citeu_top dut (.core_clk(core_clk), .arst_n(arst_n), .interrupt_level_inputs(ilvl), .evt(evt),
    .sr_wr(sr_wr), .sr_wdata(sr_wdata), .transfer_ack_input(tack), .bus_fault_input(bfault),
    .autovector_input(avec), .iack_data_in(idata), .fetch_done(fdone), .fetch_data(fdata),
    .status_word_ff(status_word_ff), .busy_ff(busy_ff), .iack_ff(iack_ff), .iack_lvl_ff(iack_lvl_ff),
    .vfetch_req_ff(vfetch_req_ff), .vfetch_addr_ff(vfetch_addr_ff), .exc_ff(exc_ff));
  citeu_periph_model partner (.core_clk(core_clk), .arst_n(arst_n), .lvl_req(lvl_req), .mode(mode),
    .dly(dly), .vec_in(vec_in), .iack_ff(iack_ff), .vfetch_req_ff(vfetch_req_ff),
    .vfetch_addr_ff(vfetch_addr_ff), .interrupt_level_inputs(ilvl), .transfer_ack_input(tack),
    .bus_fault_input(bfault), .autovector_input(avec), .iack_data_in(idata), .fetch_done(fdone),
    .fetch_data(fdata));
  // ==========================================================
  // Expectation helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] ivec(input logic [1:0] md, input logic [2:0] l, input logic [7:0] v);
    case (md)
      2'h0: return v;
      2'h1: return 8'h18 + {5'h0, l};
      2'h2: return 8'h18;
      default: return 8'h0f;
    endcase
  endfunction
  // ==========================================================
  // Drivers and checks
  task automatic pulse(input citeu_evt_t e);
    dly = 4'(rnd() % 4);
    evt = e;
    @(negedge core_clk);
    evt = '0;
  endtask
  task automatic wr_sr(input logic [15:0] v);
    sr_wr = 1'b1;
    sr_wdata = v;
    @(negedge core_clk);
    sr_wr = 1'b0;
    sr_m = v;
  endtask
  task automatic none_seen();
    repeat (6) @(negedge core_clk);
    `CHK("busy", 1'b0, busy_ff)
    `CHK("iack", 1'b0, iack_ff)
  endtask
  task automatic expect_exc(input logic [7:0] v, input logic [31:0] spc, input logic sf,
                            input logic [2:0] m, input logic setm);
    int n;
    logic [15:0] old;
    old = sr_m;
    n = 0;
    while (vfetch_req_ff !== 1'b1 && n < 200) begin @(negedge core_clk); n++; end
    `CHK("vfetch_addr", {22'h0, v, 2'b00}, vfetch_addr_ff)
    `CHK("vfetch_req", 1'b1, vfetch_req_ff)
    `CHK("busy", 1'b1, busy_ff)
    n = 0;
    while (exc_ff.valid !== 1'b1 && n < 200) begin @(negedge core_clk); n++; end
    `CHK("valid", 1'b1, exc_ff.valid)
    `CHK("busy end", 1'b0, busy_ff)
    `CHK("vector", v, exc_ff.vector)
    `CHK("stacked_pc", spc, exc_ff.stacked_pc)
    `CHK("new_pc", {22'h0, v, 2'b00} ^ 32'h00c0_0000, exc_ff.new_pc)
    `CHK("sr_copy", old, exc_ff.sr_copy)
    `CHK("short_frame", sf, exc_ff.short_frame)
    sr_m[15] = 1'b0;
    sr_m[13] = 1'b1;
    if (setm) sr_m[10:8] = m;
    `CHK("status", sr_m, status_word_ff)
  endtask
  task automatic dec(input logic [15:0] op, input logic legal, input logic [7:0] v);
    citeu_evt_t e;
    e = '0;
    e.decode_valid = 1'b1;
    e.opword = op;
    e.insn_legal = legal;
    e.insn_pc = rnd() & 32'hffff_fffe;
    e.next_pc = e.insn_pc + 32'h2;
    pulse(e);
    if (v == 8'h00) none_seen();
    else expect_exc(v, e.insn_pc, 1'b0, 3'h0, 1'b0);
  endtask
  task automatic exe(input logic [15:0] op, input logic c, input logic [7:0] v);
    citeu_evt_t e;
    e = '0;
    e.exec_done = 1'b1;
    e.opword = op;
    {e.ovf_cond, e.bounds_cond, e.divisor_zero} = {3{c}};
    e.insn_pc = rnd() & 32'hffff_fffe;
    e.next_pc = e.insn_pc + 32'h4;
    pulse(e);
    if (v == 8'h00) none_seen();
    else expect_exc(v, e.next_pc, 1'b0, 3'h0, 1'b0);
  endtask
  task automatic irq(input logic [2:0] l, input logic [1:0] md, input logic tk);
    citeu_evt_t e;
    int n;
    mode = md;
    vec_in = 8'h80 | 8'(rnd() % 128);
    lvl_req = l;
    repeat (3) @(negedge core_clk);
    `CHK("iack before boundary", 1'b0, iack_ff)
    e = '0;
    e.boundary = 1'b1;
    e.next_pc = rnd() & 32'hffff_fffe;
    pulse(e);
    if (!tk)
      none_seen();
    else
    begin
      n = 0;
      while (iack_ff !== 1'b1 && n < 20) begin @(negedge core_clk); n++; end
      `CHK("iack", 1'b1, iack_ff)
      `CHK("iack_lvl", l, iack_lvl_ff)
      `CHK("mask", l, status_word_ff[10:8])
      expect_exc(ivec(md, l, vec_in), e.next_pc, md == 2'h2, l, 1'b1);
    end
  endtask
  task automatic results();
    $display("Checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================
  // Clock, watchdog, sequence
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial
  begin
    #(4 * 20000);
    err_count++;
    results();
  end
  initial
  begin
    err_count = 0;
    checks = 0;
    seed = 32'hc77d;
    {arst_n, sr_wr, sr_wdata, lvl_req, mode, dly, vec_in} = '0;
    evt = '0;
    repeat (12) @(negedge core_clk);
    arst_n = 1'b1;
    `CHK("reset status", 16'h2700, status_word_ff)
    `CHK("reset busy", 1'b0, busy_ff)
    sr_m = 16'h2700;
    for (int k = 0; k < 4; k++)
    begin
      wr_sr(16'ha000);
      op = 16'h4e40 | ((k == 1) ? 16'hf : 16'(rnd() % 16));
      exe(op, 1'b1, 8'h20 + {4'h0, op[3:0]});
    end
    for (int k = 0; k < 4; k++)
    begin
      wr_sr(16'ha000);
      exe(16'h4e40 | 16'(k * 5), 1'b0, 8'h20 + 8'(k * 5));
    end
    for (int c = 0; c < 2; c++)
    begin
      exe(16'h4e76, c[0], c[0] ? 8'h07 : 8'h00);
      exe(16'h4180, c[0], c[0] ? 8'h06 : 8'h00);
      exe(16'h81c0, c[0], c[0] ? 8'h05 : 8'h00);
      exe(16'h80c0, c[0], c[0] ? 8'h05 : 8'h00);
    end
    dec(16'h4afa, 1'b1, 8'h04);
    dec(16'h4afb, 1'b1, 8'h04);
    dec(16'h4afc, 1'b1, 8'h04);
    dec(16'h4afd, 1'b0, 8'h04);
    dec(16'ha000 | 16'(rnd() % 4096), 1'b0, 8'h0a);
    dec(16'hf000 | 16'(rnd() % 4096), 1'b0, 8'h0b);
    dec(priv_ops[0], 1'b1, 8'h00);
    for (int k = 0; k < 10; k++)
    begin
      wr_sr(16'h8000);
      dec(priv_ops[k], 1'b1, 8'h08);
    end
    wr_sr(16'h2000);
    irq(3'h0, 2'h0, 1'b0);
    none_seen();
    wr_sr(16'h2400);
    irq(3'h4, 2'h0, 1'b0);
    none_seen();
    lvl_req = 3'h0;
    for (int l = 1; l < 7; l++)
    begin
      wr_sr({5'b00100, 3'(l - 1), 8'h00});
      irq(3'(l), 2'(l % 4), 1'b1);
      lvl_req = 3'h0;
    end
    wr_sr(16'h2700);
    irq(3'h7, 2'h1, 1'b1);
    pulse('{boundary: 1'b1, default: '0});
    none_seen();
    wr_sr(16'h2600);
    irq(3'h7, 2'h3, 1'b1);
    lvl_req = 3'h0;
    repeat (4) @(negedge core_clk);
    results();
  end
endmodule // citeu_top_tb
